// File: rtl/led_drive_reg.sv
`timescale 1ns/100ps
module led_drive_reg
  import led_status_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic init_load_in,
  input wire logic [1:0] init_rx_drive_in,
  output logic [15:0] reg_rdata_out,
  output logic led_drive_high_out,
  output logic mdio_drive_weak_out,
  output logic [1:0] rx_drive_code_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [3:0] ctrl;     // Implemented bits of the register
    logic [15:0] rdata;   // Registered read data
  } drive_reg_s;

  drive_reg_s q;
  drive_reg_s d;

  // Next state: write, strap load, read data
  always_comb
  begin
    d = q;
    if (init_load_in)
    begin
      // Strap load wins; it occurs once, right after reset
      d.ctrl[IO_RX_DRIVE_LSB +: 2] = init_rx_drive_in;
    end
    else if (reg_wr_in && (reg_addr_in == REG_IO_DRIVE_ADDR))
    begin
      d.ctrl = reg_wdata_in[3:0];
    end
    // Reserved bits 15:4 read as zero; other addresses read zero
    if (reg_addr_in == REG_IO_DRIVE_ADDR)
    begin
      d.rdata = {12'h000, q.ctrl};
    end
    else
    begin
      d.rdata = 16'h0000;
    end
  end

  // Register the state, frozen while enable is low
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q.ctrl <= IO_DRIVE_RESET[3:0];
      q.rdata <= 16'h0000;
    end
    else if (ce_in)
    begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign led_drive_high_out = q.ctrl[IO_LED_DRIVE_BIT];
  assign mdio_drive_weak_out = q.ctrl[IO_MDIO_DRIVE_BIT];
  assign rx_drive_code_out = q.ctrl[IO_RX_DRIVE_LSB +: 2];

endmodule

// File: rtl/led_status_ctrl.sv
`timescale 1ns/100ps
module led_status_ctrl
  import led_status_pkg::*;
#(
  parameter int BLINK_SHORT_CYC = BLINK_SHORT_CYCLES,
  parameter int BLINK_LONG_CYC = BLINK_LONG_CYCLES,
  parameter int REFRESH_GAP_CYC = REFRESH_GAP_CYCLES,
  parameter int POWERON_TOGGLES = POWERON_BLINK_TOGGLES
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Strap pins, asynchronous to the clock
  input wire logic [1:0] led_format_select_in,
  input wire logic collision_blink_strap_in,
  input wire logic collision_blink_enable_in,
  input wire logic blink_period_select_in,
  input wire logic poweron_blink_disable_in,
  input wire logic [1:0] rx_drive_strap_in,
  // Per-port status from the transceiver logic, same clock
  input wire logic [NUM_PORTS-1:0] link_up_in,
  input wire logic [NUM_PORTS-1:0] speed_100_in,
  input wire logic [NUM_PORTS-1:0] full_duplex_in,
  input wire logic [NUM_PORTS-1:0] collision_in,
  input wire logic [NUM_PORTS-1:0] activity_in,
  // Management register access
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // LED pins
  output logic led_shift_clk_out,
  output logic led_serial_out,
  output logic [NUM_PORTS-1:0] collision_duplex_pin_out,
  output logic [NUM_PORTS-1:0] link_activity_pin_out,
  output logic [NUM_PORTS-1:0] speed_pin_out,
  // Pad drive controls
  output logic led_drive_high_out,
  output logic mdio_drive_weak_out,
  output logic [1:0] rx_drive_code_out
);

  // ***************************************************************
  // Widths and limits
  // ***************************************************************
  localparam int BW = $clog2(BLINK_LONG_CYC + 1);
  localparam int GW = $clog2(REFRESH_GAP_CYC + 1);
  localparam int DW = $clog2(2 * SHIFT_HALF_CYCLES + 1);
  localparam logic [BW-1:0] SHORT_LIM = BW'(BLINK_SHORT_CYC - 1);
  localparam logic [BW-1:0] LONG_LIM = BW'(BLINK_LONG_CYC - 1);
  localparam logic [GW-1:0] GAP_LIM = GW'(REFRESH_GAP_CYC - 1);
  localparam logic [DW-1:0] RISE_AT = DW'(SHIFT_HALF_CYCLES - 1);
  localparam logic [DW-1:0] BIT_END = DW'(2 * SHIFT_HALF_CYCLES - 1);
  localparam logic [7:0] DIAG_LIM = 8'(POWERON_TOGGLES - 1);
  localparam logic [2:0] LAST_PORT = 3'(NUM_PORTS - 1);

  // Refuse settings the counters cannot serve
  generate
    if (BLINK_SHORT_CYC < 2 || BLINK_LONG_CYC < BLINK_SHORT_CYC)
    begin : g_bad_blink
      $error("blink cycle counts out of range");
    end
    if (REFRESH_GAP_CYC < 1 || POWERON_TOGGLES < 1 || POWERON_TOGGLES > 256)
    begin : g_bad_count
      $error("refresh gap or power-on toggle count out of range");
    end
    if (NUM_PORTS != 8)
    begin : g_bad_ports
      $error("port index sized for eight ports");
    end
  endgenerate

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [STRAP_W-1:0] strap_s1;   // Synchroniser first stage
    logic [STRAP_W-1:0] strap_s2;   // Synchroniser second stage
    logic [1:0] cap_cnt;            // Settle count before latching
    logic cfg_valid;                // Straps latched
    led_format_e fmt;               // Latched LED format
    logic colblk;                   // Latched collision-blink strap
    logic colen;                    // Latched collision-blink enable
    logic blk_long;                 // Latched long blink period
    logic diag;                     // Power-on blink running
    logic [7:0] diag_cnt;           // Toggles done in power-on blink
    logic [BW-1:0] blink_cnt;       // Free-running blink counter
    logic phase;                    // Shared blink phase
    shift_state_e seq;              // Serial sequencer state
    logic [GW-1:0] gap_cnt;         // Idle time between refreshes
    logic [DW-1:0] div_cnt;         // Position within one bit
    logic [2:0] port_idx;           // Port being shifted
    logic [1:0] bit_idx;            // Bit within port group
    logic sclk;                     // Shift clock
    logic sdata;                    // Serial data
    logic [NUM_PORTS-1:0] col_pin;  // Direct collision/duplex
    logic [NUM_PORTS-1:0] la_pin;   // Direct link/activity
    logic [NUM_PORTS-1:0] spd_pin;  // Direct speed
  } led_state_s;

  led_state_s q;
  led_state_s d;

  logic init_load;                       // One-cycle strap latch strobe
  logic colblk_ok;                       // Collision blinking allowed
  logic [NUM_PORTS-1:0][2:0] stat;       // Per-port {col, la, spd}
  logic [1:0] last_bit;                  // Last bit index of a group
  logic [2:0] nxt_port;                  // Port of the next serial bit
  logic [1:0] nxt_bit;                   // Bit of the next serial bit
  logic [BW-1:0] blink_lim;              // Active blink limit

  // ***************************************************************
  // Indicator encoding
  // ***************************************************************
  // Computes {col/duplex, link/activity, speed}; active low except link/activity in bi-color mode
  function automatic logic [2:0] port_status(
    input led_format_e fmt,
    input logic link,
    input logic spd100,
    input logic fdx,
    input logic col,
    input logic act,
    input logic phase,
    input logic col_ok,
    input logic diag
  );
    logic c;
    logic l;
    logic s;
    s = ~spd100;
    c = ~fdx ^ (col & col_ok & phase);
    if (fmt == FMT_BICOLOR)
    begin
      // Link level follows speed so that equal levels mean dark
      l = link ? spd100 : s;
    end
    else
    begin
      l = ~link;
    end
    l = l ^ (link & act & phase);
    if (diag)
    begin
      // Power-on test: col/duplex and link lamps blink together at the blink phase; speed lamp held low (on)
      c = phase;
      l = phase;
      s = 1'b0;
    end
    return {c, l, s};
  endfunction

  // Picks one serial bit out of a port group by format
  function automatic logic pick_bit(
    input led_format_e fmt,
    input logic [1:0] idx,
    input logic [2:0] st
  );
    logic b;
    if (fmt == FMT_SERIAL2)
    begin
      b = (idx == 2'd0) ? st[0] : st[1];
    end
    else
    begin
      // Three-bit groups: col/duplex, link/activity, speed
      b = st[2 - idx];
    end
    return b;
  endfunction

  // Duplex-only first bit in bi-color mode unless both straps allow blink
  assign colblk_ok = (q.fmt != FMT_BICOLOR) || (q.colblk && q.colen);

  // Per-port status, all sharing one blink phase
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
      assign stat[p] = port_status(q.fmt, link_up_in[p], speed_100_in[p],
                                   full_duplex_in[p], collision_in[p],
                                   activity_in[p], q.phase, colblk_ok,
                                   q.diag);
    end
  endgenerate

  // ***************************************************************
  // Sequencing helpers
  // ***************************************************************
  assign init_load = !q.cfg_valid && (q.cap_cnt == STRAP_SETTLE_CYCLES);
  assign last_bit = (q.fmt == FMT_SERIAL2) ? 2'd1 : 2'd2;
  assign blink_lim = q.blk_long ? LONG_LIM : SHORT_LIM;

  // Next bit position; port order runs upward
  always_comb
  begin
    if (q.bit_idx == last_bit)
    begin
      nxt_bit = 2'd0;
      nxt_port = q.port_idx + 3'd1;
    end
    else
    begin
      nxt_bit = q.bit_idx + 2'd1;
      nxt_port = q.port_idx;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    d = q;
    // Straps come from pins: two flops before use
    d.strap_s1 = {rx_drive_strap_in, poweron_blink_disable_in,
                  blink_period_select_in, collision_blink_enable_in,
                  collision_blink_strap_in, led_format_select_in};
    d.strap_s2 = q.strap_s1;

    // Latch straps once the synchroniser has settled after reset
    if (init_load)
    begin
      d.cfg_valid = 1'b1;
      d.fmt = led_format_e'(q.strap_s2[STRAP_MODE_LSB +: 2]);
      d.colblk = q.strap_s2[STRAP_COLBLK_BIT];
      d.colen = q.strap_s2[STRAP_COLEN_BIT];
      d.blk_long = q.strap_s2[STRAP_BLKSEL_BIT];
      d.diag = ~q.strap_s2[STRAP_POWERON_BLINK_DISABLE_BIT];
    end
    else if (!q.cfg_valid)
    begin
      d.cap_cnt = q.cap_cnt + 2'd1;
    end

    // Free-running blink timer; phase toggles each period
    if (q.blink_cnt >= blink_lim)
    begin
      d.blink_cnt = '0;
      d.phase = ~q.phase;
      if (q.diag)
      begin
        // Power-on blink ends after a fixed number of toggles
        d.diag_cnt = q.diag_cnt + 8'd1;
        if (q.diag_cnt == DIAG_LIM)
        begin
          d.diag = 1'b0;
        end
      end
    end
    else
    begin
      d.blink_cnt = q.blink_cnt + 1'b1;
    end

    // Direct pins only in mono-color mode; else held dark
    if (q.cfg_valid && (q.fmt == FMT_DIRECT))
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        d.col_pin[p] = stat[p][2];
        d.la_pin[p] = stat[p][1];
        d.spd_pin[p] = stat[p][0];
      end
    end
    else
    begin
      d.col_pin = '1;
      d.la_pin = '1;
      d.spd_pin = '1;
    end

    // Serial chain refresh
    unique case (q.seq)
      SEQ_GAP:
      begin
        // Wait out the gap, then start from port 0
        if (q.gap_cnt != '0)
        begin
          d.gap_cnt = q.gap_cnt - 1'b1;
        end
        else if (q.cfg_valid && (q.fmt != FMT_DIRECT))
        begin
          d.seq = SEQ_SHIFT;
          d.port_idx = 3'd0;
          d.bit_idx = 2'd0;
          d.div_cnt = '0;
          d.sdata = pick_bit(q.fmt, 2'd0, stat[0]);
        end
      end
      SEQ_SHIFT:
      begin
        // Data set while clock low, clock rises mid-bit
        d.div_cnt = q.div_cnt + 1'b1;
        if (q.div_cnt == RISE_AT)
        begin
          d.sclk = 1'b1;
        end
        if (q.div_cnt == BIT_END)
        begin
          d.div_cnt = '0;
          d.sclk = 1'b0;
          if ((q.port_idx == LAST_PORT) && (q.bit_idx == last_bit))
          begin
            // Chain done; idle low until the next refresh
            d.seq = SEQ_GAP;
            d.gap_cnt = GAP_LIM;
            d.sdata = 1'b0;
          end
          else
          begin
            d.port_idx = nxt_port;
            d.bit_idx = nxt_bit;
            d.sdata = pick_bit(q.fmt, nxt_bit, stat[nxt_port]);
          end
        end
      end
    endcase
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Constants only under reset; straps are caught after release
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q <= '0;
      q.fmt <= FMT_SERIAL3;
      q.seq <= SEQ_GAP;
      q.col_pin <= '1;
      q.la_pin <= '1;
      q.spd_pin <= '1;
    end
    else if (ce_in)
    begin
      q <= d;
    end
  end

  // ***************************************************************
  // Drive strength register
  // ***************************************************************
  led_drive_reg u_drive_reg (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .init_load_in(init_load),
    .init_rx_drive_in(q.strap_s2[STRAP_RXDRV_LSB +: 2]),
    .reg_rdata_out(reg_rdata_out),
    .led_drive_high_out(led_drive_high_out),
    .mdio_drive_weak_out(mdio_drive_weak_out),
    .rx_drive_code_out(rx_drive_code_out)
  );

  // ***************************************************************
  // Outputs, all from flops
  // ***************************************************************
  assign led_shift_clk_out = q.sclk;
  assign led_serial_out = q.sdata;
  assign collision_duplex_pin_out = q.col_pin;
  assign link_activity_pin_out = q.la_pin;
  assign speed_pin_out = q.spd_pin;

endmodule

// File: rtl/led_status_pkg.sv
// Behaviour
// - Latch LED mode and blink straps at reset
// - Mode 00: 3-bit serial, active-low indicators
// - Serial stream runs port 0 to port 7
// - 2-bit mode: speed first, then link/activity
// - 3-bit mode: col/duplex, link/activity, speed
// - Mode 10 bi-color; strap picks col/duplex or duplex
// - Col/duplex low full, high half, blinks
// - Bi-color collision blink off when enable strap 0
// - Link/act level by mode and speed
// - Link/act blinks while port has traffic
// - Speed low at 100 Mb/s, high at 10
// - Strap picks 48 or 128 ms blink
// - Bi-color: equal levels dark, green, yellow
// - Mode 11 drives three direct pins per port
// - Drive register bit 0 sets LED strength
// - Drive register bit 1 sets management strength
// - Drive register bits 3:2 receive drive, strap init
// - Power-on LED blink unless disable strap high
package led_status_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int NUM_PORTS = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLINK_SHORT_MS = 48;
  localparam int BLINK_LONG_MS = 128;
  localparam int BLINK_SHORT_CYCLES = BLINK_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BLINK_LONG_CYCLES = BLINK_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_NS = 500;
  localparam int SHIFT_HALF_CYCLES = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_GAP_US = 100;
  localparam int REFRESH_GAP_CYCLES = REFRESH_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERON_BLINK_TOGGLES = 6;
  localparam int RESET_MIN_MS = 1;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  // ***************************************************************
  // Strap vector layout (after synchroniser)
  // ***************************************************************
  localparam int STRAP_W = 8;
  localparam int STRAP_MODE_LSB = 0;
  localparam int STRAP_COLBLK_BIT = 2;
  localparam int STRAP_COLEN_BIT = 3;
  localparam int STRAP_BLKSEL_BIT = 4;
  localparam int STRAP_POWERON_BLINK_DISABLE_BIT = 5;
  localparam int STRAP_RXDRV_LSB = 6;

  // ***************************************************************
  // Drive strength register
  // ***************************************************************
  localparam logic [4:0] REG_IO_DRIVE_ADDR = 5'h14;
  localparam int IO_LED_DRIVE_BIT = 0;
  localparam int IO_MDIO_DRIVE_BIT = 1;
  localparam int IO_RX_DRIVE_LSB = 2;
  localparam logic [15:0] IO_DRIVE_RESET = 16'h0000;

  // ***************************************************************
  // Enumerations
  // ***************************************************************
  typedef enum logic [1:0] {
    FMT_SERIAL3 = 2'b00,
    FMT_SERIAL2 = 2'b01,
    FMT_BICOLOR = 2'b10,
    FMT_DIRECT = 2'b11
  } led_format_e;

  typedef enum logic {
    SEQ_GAP = 1'b0,
    SEQ_SHIFT = 1'b1
  } shift_state_e;

endpackage

// File: sim/led_chain_model.sv
`timescale 1ns/100ps
module led_chain_model (
  input wire logic clk_sys_in,
  input wire logic led_shift_clk_in,
  input wire logic led_serial_in,
  output logic [23:0] chain_out,
  output logic [5:0] bits_out
);
  // ****************************
  // External TTL shift chain
  // ****************************
  logic shift_prev = 1'b0; // Shift clock one cycle back
  logic [3:0] low_run = 4'h0; // Cycles with shift clock low
  initial chain_out = 24'h000000;
  initial bits_out = 6'h00;
  // Take a bit on each shift clock rise; a long low spell marks a new frame
  always @(posedge clk_sys_in)
  begin
    shift_prev <= led_shift_clk_in;
    if (led_shift_clk_in && !shift_prev)
    begin
      chain_out <= {chain_out[22:0], led_serial_in};
      bits_out <= bits_out + 6'h01;
    end
    if (led_shift_clk_in)
      low_run <= 4'h0;
    else if (low_run != 4'hF)
      low_run <= low_run + 4'h1;
    // Bit gaps are 5 low cycles, so 7 only happens between frames
    if (low_run == 4'h7)
      bits_out <= 6'h00;
  end
endmodule

// File: sim/led_status_ctrl_props.sv
`timescale 1ns/100ps
module led_status_ctrl_props
  import led_status_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [1:0] led_format_select_in,
  input wire logic poweron_blink_disable_in,
  input wire logic [NUM_PORTS-1:0] speed_100_in,
  input wire logic [NUM_PORTS-1:0] full_duplex_in,
  input wire logic [NUM_PORTS-1:0] collision_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic led_shift_clk_out,
  input wire logic led_serial_out,
  input wire logic [NUM_PORTS-1:0] collision_duplex_pin_out,
  input wire logic [NUM_PORTS-1:0] link_activity_pin_out,
  input wire logic [NUM_PORTS-1:0] speed_pin_out,
  input wire logic led_drive_high_out,
  input wire logic mdio_drive_weak_out,
  input wire logic [1:0] rx_drive_code_out
);
  // ****************************
  // Helper state
  // ****************************
  typedef struct packed {
    logic [2:0] warm; // Enabled edges since reset, saturating
    logic [1:0] fmt; // Format as the strap latch sees it
  } mon_s;
  mon_s mon_q;
  mon_s mon_d;
  // Mirror the strap latch at the third enabled edge
  always_comb
  begin
    mon_d = mon_q;
    if (ce_in && mon_q.warm != 3'h7)
      mon_d.warm = mon_q.warm + 3'h1;
    if (ce_in && mon_q.warm == 3'h2)
      mon_d.fmt = led_format_select_in;
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mon_q <= '0;
    else
      mon_q <= mon_d;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // ****************************
  // Serial link shape
  // ****************************
  sequence clk_high_burst;
    led_shift_clk_out[*5] ##1 !led_shift_clk_out;
  endsequence
  sequence clk_low_wait;
    !led_shift_clk_out[*5];
  endsequence
  a_shift_high_len: assert property ($rose(led_shift_clk_out) |-> clk_high_burst)
    else $error("Shift clock high time wrong");
  a_shift_low_len: assert property ($fell(led_shift_clk_out) |-> clk_low_wait)
    else $error("Shift clock low time short");
  a_data_stable_edge: assert property ($rose(led_shift_clk_out) |->
    $stable(led_serial_out)[*5]) else $error("Serial data moved near clock rise");
  a_serial_off_direct: assert property (mon_q.warm >= 3'h3 && mon_q.fmt == 2'b11 |->
    !led_shift_clk_out && !led_serial_out) else $error("Serial pins active in direct mode");
  a_direct_off_serial: assert property (mon_q.warm == 3'h7 && mon_q.fmt != 2'b11 |->
    &{collision_duplex_pin_out, link_activity_pin_out, speed_pin_out})
    else $error("Direct pins active in serial mode");
  a_speed_direct_pin: assert property (mon_q.warm == 3'h7 && mon_q.fmt == 2'b11 &&
    poweron_blink_disable_in |=> speed_pin_out == ~$past(speed_100_in))
    else $error("Speed pin wrong");
  a_duplex_direct_pin: assert property (mon_q.warm == 3'h7 && mon_q.fmt == 2'b11 &&
    poweron_blink_disable_in && collision_in == '0 |=>
    collision_duplex_pin_out == ~$past(full_duplex_in)) else $error("Duplex pin wrong");
  // ****************************
  // Drive register
  // ****************************
  a_write_drive_out: assert property (ce_in && reg_wr_in && mon_q.warm >= 3'h4 &&
    reg_addr_in == REG_IO_DRIVE_ADDR |=> {rx_drive_code_out, mdio_drive_weak_out,
    led_drive_high_out} == $past(reg_wdata_in[3:0])) else $error("Drive write lost");
  // Read data trails the register by one cycle, so a write just made is not yet visible
  a_read_mirror: assert property (ce_in && mon_q.warm >= 3'h4 &&
    reg_addr_in == REG_IO_DRIVE_ADDR |=> reg_rdata_out == {12'h000, $past(rx_drive_code_out),
    $past(mdio_drive_weak_out), $past(led_drive_high_out)}) else $error("Drive read mismatch");
  a_read_unmapped: assert property (ce_in && reg_addr_in != REG_IO_DRIVE_ADDR |=>
    reg_rdata_out == 16'h0000) else $error("Unmapped read not zero");
endmodule
bind led_status_ctrl led_status_ctrl_props u_props (.clk_sys_in, .rst_b_in, .ce_in,
  .led_format_select_in, .poweron_blink_disable_in, .speed_100_in, .full_duplex_in,
  .collision_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
  .led_shift_clk_out, .led_serial_out, .collision_duplex_pin_out, .link_activity_pin_out,
  .speed_pin_out, .led_drive_high_out, .mdio_drive_weak_out, .rx_drive_code_out);

// File: sim/led_status_ctrl_tb_top.sv
`timescale 1ns/100ps
module led_status_ctrl_tb_top;
  import led_status_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in, ce_in, col_strap, col_en, blk_sel, pb_dis, wr; // Drives
  logic [1:0] fmt, rx_strap;
  logic [7:0] link, spd, fdx, col, act; // Port status
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic sclk, sdata, drv_led, drv_mdio; // Observed
  logic [1:0] drv_rx;
  logic [7:0] col_pin, la_pin, spd_pin;
  logic [23:0] chain;
  logic [5:0] nbits;
  int fail_count, comparisons, seed, reg_model;
  // Short counts keep the run brief
  led_status_ctrl #(.BLINK_SHORT_CYC(8), .BLINK_LONG_CYC(16), .REFRESH_GAP_CYC(4),
    .POWERON_TOGGLES(2)) u_led_status_ctrl (.clk_sys_in, .rst_b_in, .ce_in,
    .led_format_select_in(fmt), .collision_blink_strap_in(col_strap),
    .collision_blink_enable_in(col_en), .blink_period_select_in(blk_sel),
    .poweron_blink_disable_in(pb_dis), .rx_drive_strap_in(rx_strap), .link_up_in(link),
    .speed_100_in(spd), .full_duplex_in(fdx), .collision_in(col), .activity_in(act),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .led_shift_clk_out(sclk), .led_serial_out(sdata), .collision_duplex_pin_out(col_pin),
    .link_activity_pin_out(la_pin), .speed_pin_out(spd_pin), .led_drive_high_out(drv_led),
    .mdio_drive_weak_out(drv_mdio), .rx_drive_code_out(drv_rx));
  led_chain_model u_led_chain_model (.clk_sys_in, .led_shift_clk_in(sclk),
    .led_serial_in(sdata), .chain_out(chain), .bits_out(nbits));
  always #50 clk_sys_in = ~clk_sys_in;
  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Straps must be stable across reset; long enough for the chain to see a gap
  task automatic do_reset(input logic [1:0] f, input logic dis);
    rst_b_in = 1'b0;
    fmt = f;
    pb_dis = dis;
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
  endtask
  task automatic rnd_status();
    link = 8'($random(seed));
    spd = 8'($random(seed));
    fdx = 8'($random(seed));
  endtask
  // Reference frame, port 0 first
  function automatic logic [23:0] exp_frame(input logic [1:0] f);
    bit q[$];
    logic [23:0] e;
    e = 24'h000000;
    for (int p = 0; p < 8; p++)
    begin
      if (f == 2'b01)
      begin
        q.push_back(!spd[p]);
        q.push_back(!link[p]);
      end
      else
      begin
        q.push_back(!fdx[p]);
        q.push_back(f == 2'b10 ? (link[p] ? spd[p] : !spd[p]) : !link[p]);
        q.push_back(!spd[p]);
      end
    end
    foreach (q[i]) e = {e[22:0], logic'(q[i])};
    return e;
  endfunction
  task automatic serial_case(input logic [1:0] f);
    int t;
    logic [23:0] got;
    rnd_status();
    col = (f == 2'b10) ? 8'hFF : 8'h00; // Bi-color collisions must not blink
    do_reset(f, 1'b1);
    fmt = 2'b11; // Latched format must hold
    t = 0;
    while (nbits != ((f == 2'b01) ? 6'h10 : 6'h18) && t < 2000)
    begin
      @(negedge clk_sys_in);
      t++;
    end
    got = (f == 2'b01) ? {8'h00, chain[15:0]} : chain;
    chk(got, exp_frame(f), "frame");
    $display("Test serial format %0d done", f);
  endtask
  task automatic blink_case(input logic sel);
    int t;
    logic v;
    blk_sel = sel;
    link = 8'hFF;
    act = 8'h01;
    col = 8'h00;
    do_reset(2'b11, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      v = la_pin[0];
      t = 0;
      while (la_pin[0] === v && t < 40)
      begin
        @(negedge clk_sys_in);
        t++;
      end
    end
    chk(24'(t), sel ? 24'h000010 : 24'h000008, "blink period");
    chk(24'(la_pin[7:1]), 24'h000000, "idle ports steady");
    act = 8'h00;
    $display("Test blink select %0d done", sel);
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(negedge clk_sys_in);
    wr = 1'b0;
    if (a == REG_IO_DRIVE_ADDR)
      reg_model = d & 16'h000F;
    chk(24'({drv_rx, drv_mdio, drv_led}), 24'(reg_model), "drive");
    // Let an edge pass so a following write does not raise the strobe at once
    @(negedge clk_sys_in);
  endtask
  task automatic reg_rd(input logic [4:0] a);
    addr = a;
    @(negedge clk_sys_in);
    chk(24'(rdata), a == REG_IO_DRIVE_ADDR ? 24'(reg_model) : 24'h0, "read");
  endtask
  // ****************************
  // Main sequence
  // ****************************
  initial
  begin
    seed = 99533;
    fail_count = 0;
    comparisons = 0;
    {ce_in, col_strap, col_en, blk_sel, wr, addr, wdata} = '0;
    ce_in = 1'b1;
    {link, spd, fdx, col, act} = '0;
    rx_strap = 2'b10;
    for (int f = 0; f < 3; f++)
      serial_case(2'(f));
    rnd_status();
    col = 8'h00; // Leftover collisions would blink the duplex pins
    do_reset(2'b11, 1'b1);
    chk({col_pin, la_pin, spd_pin}, ~{fdx, link, spd}, "direct");
    rnd_status();
    spd = 8'h00;
    do_reset(2'b11, 1'b0);
    chk(24'(spd_pin), 24'h000000, "power-on blink");
    $display("Test direct and power-on done");
    blink_case(1'b0);
    blink_case(1'b1);
    reg_model = 32'h8;
    reg_rd(REG_IO_DRIVE_ADDR);
    reg_wr(REG_IO_DRIVE_ADDR, 16'hFFFF);
    reg_rd(REG_IO_DRIVE_ADDR);
    reg_wr(REG_IO_DRIVE_ADDR, 16'h0005);
    reg_wr(5'h13, 16'h000A);
    reg_rd(5'h13);
    reg_rd(REG_IO_DRIVE_ADDR);
    $display("Test drive register done");
    finish_test();
  end
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial
  begin
    #(100 * 20000);
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule
